// ### afs_defines.vh
/*
 axis fault and restart supervisor: fault codes, widths and mode numbers.
 assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef AFS_DEFINES_VH
`define AFS_DEFINES_VH

// fault codes seen by the controller host
`define AFS_FAULT_NONE 8'h00
`define AFS_FAULT_ILLEGAL_READ 8'h3C
`define AFS_FAULT_BAD_HOME_MD 8'h3D
`define AFS_FAULT_NOT_CLEAR 8'h3E
`define AFS_FAULT_ILLEGAL_CHANGE 8'h3F
// offset added for the programming device port
`define AFS_PGM_OFFSET 8'h80
// mode numbers
`define AFS_MODE_SET_HOME 5'h05
`define AFS_MODE_FOLLOW 5'h04
// default widths
`define AFS_POS_W 24
`define AFS_DRIFT_W 12

`endif

// ### afs_encoder_check.v
/*
 encoder plausibility checks: reading against step count and usable range,
 and the change limit between consecutive valid samples.
 assumes encoder samples are synchronous to clk and arrive with a valid strobe.
*/
`timescale 1ns/1ps
`include "afs_defines.vh"

module afs_encoder_check #(
    parameter POS_W = `AFS_POS_W
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // encoder sample
    input wire encValid,
    input wire [POS_W-1:0] encReading,
    // configuration from machine data
    input wire [POS_W-1:0] stepCount,
    input wire [POS_W-1:0] maxStepChange,
    input wire [POS_W-1:0] rangeLow,
    input wire [POS_W-1:0] rangeHigh,
    // results, one-cycle flags registered one cycle after the sample
    output reg readIllegal,
    output reg outOfRange,
    output reg changeIllegal
);

    reg [POS_W-1:0] lastReading_reg;
    reg haveLast_reg;
    wire [POS_W-1:0] delta;

    function [POS_W-1:0] absDiff;
        input [POS_W-1:0] a;
        input [POS_W-1:0] b;
        begin
            absDiff = (a > b) ? (a - b) : (b - a);
        end
    endfunction

    assign delta = absDiff(encReading, lastReading_reg);

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            lastReading_reg <= {POS_W{1'b0}};
            haveLast_reg <= 1'b0;
            readIllegal <= 1'b0;
            outOfRange <= 1'b0;
            changeIllegal <= 1'b0;
        end
        else
        begin
            readIllegal <= encValid && (encReading >= stepCount);
            outOfRange <= encValid && ((encReading < rangeLow) || (encReading > rangeHigh));
            // a wrap across the step count looks like a huge jump; only legal small steps pass
            changeIllegal <= encValid && haveLast_reg && (delta > maxStepChange)
                && (absDiff(delta, stepCount) > maxStepChange);
            if (encValid)
            begin
                lastReading_reg <= encReading;
                haveLast_reg <= 1'b1;
            end
        end
    end

endmodule // afs_encoder_check

// ### afs_host_model.sv
/*
 controller host model: supplies machine data and announces changes.
 assumes one controlling processor and 24-bit positions.
*/
`timescale 1ns/1ps

module afs_host_model #(
    parameter POS_W = 24
) (
    // clock
    input wire clk,
    // machine data to the supervisor
    output logic mdValid,
    output logic mdChange,
    output logic [POS_W-1:0] mdStepCount,
    output logic [POS_W-1:0] mdMaxStepChange,
    output logic [POS_W-1:0] mdRangeLow,
    output logic [POS_W-1:0] mdRangeHigh,
    output logic [POS_W-1:0] mdHomeCoord,
    output logic [POS_W-1:0] mdHomeReading,
    output logic [POS_W-1:0] mdRefCoord
);
    // sole processor on the axis, so no arbitration is modelled
    // link watchdog codes belong to the programming side, never sent here
    initial
    begin
        mdValid = 1'b1;
        mdChange = 1'b0;
        mdStepCount = 24'h000190;
        mdMaxStepChange = 24'h000064;
        mdRangeLow = 24'h00000A;
        mdRangeHigh = 24'h000186;
        mdHomeCoord = 24'h000100;
        mdHomeReading = 24'h000032;
        mdRefCoord = 24'h000000;
    end

    task automatic push(input logic [POS_W-1:0] homeReading);
        @(posedge clk);
        mdHomeReading <= homeReading;
        mdChange <= 1'b1;
        @(posedge clk);
        mdChange <= 1'b0;
    endtask
endmodule // afs_host_model

// ### afs_supervisor.v
/*
 axis fault and restart supervisor for one axis with absolute or incremental
 position encoder. holds fault codes for host and programming port, forces
 following-error mode and neutral speed output, rebuilds the coordinate
 system and manages what survives a restart.
 assumes single-clock synchronous inputs, one controlling processor, and a
 machine data store outside that pulses mdValid/mdChange.
*/
// Function
// [RL1] fault 60 on impossible reading, or with home set, reading outside range
// [RL2] fault 60 aborts job, neutral speed output, following-error mode, loop off
// [RL3] machine data change ends that mode; still faulty re-enters at once
// [RL4] fault 61 when stored home coordinate and reading pairing is forbidden
// [RL5] fault 62 on coordinate build out of range; working home cleared
// [RL6] rebuild on set-home mode 5, startup with valid data, data transfer
// [RL7] fault 63 on illegal change: abort, neutral output, following mode
// [RL8] programming side raises watchdog error when no link; not here
// [RL9] only one processor may access the module
// [RL10] bus reset pulse resets everything and cancels the job; here homeReading_reg, and with battery data/drift and absolute-variant home, survive it
// [RL11] incremental variant clears reference and starts in following mode
// [RL12] without backup lose data, programs, home, drift, offsets
// [RL13] incremental with backup reports reference coordinate as actual value
// [RL14] absolute with backup: position if home set, else home coordinate
// [RL15] programming port code is controller code plus 80H
// [RL16] latest fault held for both readers until next fault or reset
`timescale 1ns/1ps
`include "afs_defines.vh"

module afs_supervisor #(
    parameter POS_W = `AFS_POS_W,
    parameter DRIFT_W = `AFS_DRIFT_W,
    parameter IS_ABSOLUTE = 1
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // backplane reset pulse and restart context
    input wire busResetPulse,
    input wire batteryOk,
    // encoder
    input wire encValid,
    input wire [POS_W-1:0] encReading,
    // machine data from the store
    input wire mdValid,
    input wire mdChange,
    input wire [POS_W-1:0] mdStepCount,
    input wire [POS_W-1:0] mdMaxStepChange,
    input wire [POS_W-1:0] mdRangeLow,
    input wire [POS_W-1:0] mdRangeHigh,
    input wire [POS_W-1:0] mdHomeCoord,
    input wire [POS_W-1:0] mdHomeReading,
    input wire [POS_W-1:0] mdRefCoord,
    // job and mode control
    input wire jobStart,
    input wire [4:0] modeSel,
    input wire modeStrobe,
    input wire [DRIFT_W-1:0] driftIn,
    input wire driftLoad,
    input wire [DRIFT_W-1:0] speedCmd,
    // status
    output reg [7:0] hostFaultCode,
    output reg [7:0] pgmFaultCode,
    output reg faultPulse,
    output reg jobActive,
    output reg followMode,
    output reg loopEnable,
    output reg homeValid,
    output reg dataValid,
    output reg [POS_W-1:0] actualValue,
    output reg [DRIFT_W-1:0] speedOut
);

    localparam ST_RUN = 2'd0;
    localparam ST_BUILD = 2'd1;
    localparam ST_FOLLOW = 2'd2;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [POS_W-1:0] homeReading_reg;
    reg [DRIFT_W-1:0] drift_reg;
    reg startup_reg;
    reg latchedBattery_reg;
    reg hostFault60Sticky_reg;
    wire softReset;
    wire readIllegal;
    wire outOfRange;
    wire changeIllegal;
    wire fault60;
    wire homePairBad;
    wire buildReq;

    assign softReset = !nrst || busResetPulse; // [RL10]

    afs_encoder_check #(
        .POS_W(POS_W)
    ) u_check (
        .clk(clk),
        .nrst(!softReset),
        .encValid(encValid),
        .encReading(encReading),
        .stepCount(mdStepCount),
        .maxStepChange(mdMaxStepChange),
        .rangeLow(mdRangeLow),
        .rangeHigh(mdRangeHigh),
        .readIllegal(readIllegal),
        .outOfRange(outOfRange),
        .changeIllegal(changeIllegal)
    );

    // range only counts as illegal once a home point gives it meaning
    assign fault60 = readIllegal || (homeValid && outOfRange); // [RL1]
    assign homePairBad = mdHomeReading >= mdStepCount; // [RL4]
    assign buildReq = (modeStrobe && modeSel == `AFS_MODE_SET_HOME)
        || (startup_reg && mdValid) || (mdChange && mdValid); // [RL6]

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:
                if (buildReq)
                    state_next = ST_BUILD;
            ST_BUILD:
                state_next = ST_RUN;
            ST_FOLLOW:
                // a data change leaves following mode; a persisting fault re-enters next cycle
                if (mdChange) // [RL3]
                    state_next = buildReq ? ST_BUILD : ST_RUN;
                else if (modeStrobe && modeSel != `AFS_MODE_FOLLOW)
                    state_next = ST_RUN;
            default:
                state_next = ST_FOLLOW;
        endcase
        if (IS_ABSOLUTE && (fault60 || changeIllegal) && !mdChange)
            state_next = ST_FOLLOW; // [RL2] [RL7]
        if (IS_ABSOLUTE && (fault60 || changeIllegal) && state_reg != ST_FOLLOW)
            state_next = ST_FOLLOW; // [RL3]
        if (modeStrobe && modeSel == `AFS_MODE_FOLLOW)
            state_next = ST_FOLLOW;
    end

    always @(posedge clk)
    begin
        if (softReset)
        begin
            // incremental variant always wakes in following mode, absolute in run
            state_reg <= IS_ABSOLUTE ? ST_RUN : ST_FOLLOW; // [RL11]
            startup_reg <= 1'b1;
            latchedBattery_reg <= 1'b0;
            hostFaultCode <= `AFS_FAULT_NONE;
            pgmFaultCode <= `AFS_FAULT_NONE;
            faultPulse <= 1'b0;
            jobActive <= 1'b0; // [RL10]
            followMode <= !IS_ABSOLUTE;
            loopEnable <= IS_ABSOLUTE ? 1'b1 : 1'b0;
            speedOut <= {DRIFT_W{1'b0}};
            actualValue <= {POS_W{1'b0}};
            hostFault60Sticky_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            faultPulse <= 1'b0;
            if (startup_reg)
            begin
                startup_reg <= 1'b0;
                latchedBattery_reg <= batteryOk;
            end
            followMode <= (state_next == ST_FOLLOW);
            loopEnable <= (state_next != ST_FOLLOW); // [RL2]
            if (state_next == ST_FOLLOW)
                jobActive <= 1'b0; // [RL2] [RL7]
            else if (jobStart)
                jobActive <= 1'b1;
            // neutral output is the compensated drift, zero if none kept
            speedOut <= (state_next == ST_FOLLOW) ? drift_reg : speedCmd; // [RL2] [RL7]
            hostFault60Sticky_reg <= fault60;
            if (IS_ABSOLUTE && changeIllegal)
            begin
                hostFaultCode <= `AFS_FAULT_ILLEGAL_CHANGE; // [RL7] [RL16]
                pgmFaultCode <= `AFS_FAULT_ILLEGAL_CHANGE + `AFS_PGM_OFFSET; // [RL15]
                faultPulse <= 1'b1;
            end
            else if (IS_ABSOLUTE && fault60)
            begin
                hostFaultCode <= `AFS_FAULT_ILLEGAL_READ; // [RL1] [RL16]
                pgmFaultCode <= `AFS_FAULT_ILLEGAL_READ + `AFS_PGM_OFFSET; // [RL15]
                faultPulse <= !hostFault60Sticky_reg;
            end
            else if (IS_ABSOLUTE && state_reg == ST_BUILD && homePairBad)
            begin
                hostFaultCode <= `AFS_FAULT_BAD_HOME_MD; // [RL4] [RL16]
                pgmFaultCode <= `AFS_FAULT_BAD_HOME_MD + `AFS_PGM_OFFSET; // [RL15]
                faultPulse <= 1'b1;
            end
            else if (IS_ABSOLUTE && state_reg == ST_BUILD && outOfRange)
            begin
                hostFaultCode <= `AFS_FAULT_NOT_CLEAR; // [RL5] [RL16]
                pgmFaultCode <= `AFS_FAULT_NOT_CLEAR + `AFS_PGM_OFFSET; // [RL15]
                faultPulse <= 1'b1;
            end
            // actual value reporting
            if (!IS_ABSOLUTE)
                actualValue <= dataValid ? mdRefCoord : {POS_W{1'b0}}; // [RL13]
            else if (homeValid)
                actualValue <= mdHomeCoord + (encReading - homeReading_reg); // [RL14]
            else
                actualValue <= mdHomeCoord; // [RL14]
        end
    end

    // restart-sensitive state: survives a bus reset pulse only under battery backup, except homeReading_reg; nrst always clears it
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            homeValid <= 1'b0;
            dataValid <= 1'b0;
            homeReading_reg <= {POS_W{1'b0}};
            drift_reg <= {DRIFT_W{1'b0}};
        end
        else if (busResetPulse && !batteryOk)
        begin
            homeValid <= 1'b0; // [RL12]
            dataValid <= 1'b0; // [RL12]
            drift_reg <= {DRIFT_W{1'b0}}; // [RL12]
        end
        else if (busResetPulse && !IS_ABSOLUTE)
            homeValid <= 1'b0; // [RL11]
        else
        begin
            if (mdValid)
                dataValid <= 1'b1; // [RL12]
            if (driftLoad)
                drift_reg <= driftIn;
            if (state_reg == ST_BUILD && IS_ABSOLUTE)
            begin
                if (outOfRange || homePairBad)
                    homeValid <= 1'b0; // [RL5]
                else
                begin
                    homeValid <= 1'b1; // [RL6]
                    homeReading_reg <= mdHomeReading;
                end
            end
            else if (!IS_ABSOLUTE && modeStrobe && modeSel == `AFS_MODE_SET_HOME)
                homeValid <= 1'b1;
        end
    end

endmodule // afs_supervisor

// ### afs_supervisor_assertions.sv
/*
 checker for supervisor fault codes, following mode and restarts.
 assumes the absolute variant, one clk domain, bound below.
*/
`timescale 1ns/1ps
`include "afs_defines.vh"

module afs_supervisor_assertions #(
    parameter POS_W = 24,
    parameter DRIFT_W = 12
) (
    // clock and reset
    input wire clk,
    input wire nrst,
    // watched inputs
    input wire busResetPulse,
    input wire batteryOk,
    input wire encValid,
    input wire [POS_W-1:0] encReading,
    input wire [POS_W-1:0] mdStepCount,
    input wire mdChange,
    // watched outputs
    input wire [7:0] hostFaultCode,
    input wire [7:0] pgmFaultCode,
    input wire jobActive,
    input wire followMode,
    input wire loopEnable,
    input wire homeValid,
    input wire dataValid,
    input wire [DRIFT_W-1:0] speedOut
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_pgm_code_offset: assert property (hostFaultCode != 8'h00 |-> pgmFaultCode == hostFaultCode + 8'h80)
        else $error("programming port code not host code plus offset");
    a_code_holds: assert property ($changed(hostFaultCode) && $past(nrst) && !$past(busResetPulse)
        |-> hostFaultCode != 8'h00)
        else $error("fault code cleared without reset");
    a_follow_loop_off: assert property (followMode |-> !loopEnable)
        else $error("loop enabled in following mode");
    a_fault_aborts: assert property ($changed(hostFaultCode) && hostFaultCode inside {8'h3C, 8'h3F}
        |-> followMode && !jobActive)
        else $error("fault did not abort job into following mode");
    a_bad_read_code: assert property (encValid && encReading >= mdStepCount && !busResetPulse ##1 !busResetPulse
        |=> hostFaultCode inside {8'h3C, 8'h3F})
        else $error("impossible reading not reported two cycles later");
    a_bus_reset_clears: assert property (busResetPulse |=> !jobActive && hostFaultCode == 8'h00 && speedOut == 12'h000)
        else $error("bus reset left job or code");
    a_no_backup_loss: assert property (busResetPulse && !batteryOk |=> !homeValid && !dataValid)
        else $error("data kept without backup");
    a_backup_keeps: assert property (busResetPulse && batteryOk && dataValid |=> dataValid)
        else $error("backed-up data lost on restart");
    a_md_change_exit: assert property (followMode && mdChange && !encValid && !busResetPulse |=> !followMode)
        else $error("machine data change did not end following mode");

    c_bad_read: cover property (hostFaultCode == 8'h3C);
    c_bad_change: cover property (hostFaultCode == 8'h3F);
    c_bad_home: cover property (hostFaultCode == 8'h3D);
    c_backed_restart: cover property (busResetPulse && batteryOk && dataValid);
endmodule // afs_supervisor_assertions

bind afs_supervisor afs_supervisor_assertions #(.POS_W(POS_W), .DRIFT_W(DRIFT_W)) afs_supervisor_assertions_inst (
    .clk, .nrst, .busResetPulse, .batteryOk, .encValid, .encReading, .mdStepCount, .mdChange,
    .hostFaultCode, .pgmFaultCode, .jobActive, .followMode, .loopEnable, .homeValid, .dataValid, .speedOut);

// ### tb_axis_fault_and_restart_supervisor.sv
/*
 testbench for the supervisor: faults, following mode, restarts.
 assumes the absolute variant and the host model for machine data.
*/
`timescale 1ns/1ps
`include "afs_defines.vh"

module tb_axis_fault_and_restart_supervisor;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic busResetPulse = 1'b0;
    logic batteryOk = 1'b1;
    logic encValid = 1'b0;
    logic [23:0] encReading = 24'h000000;
    logic jobStart = 1'b0;
    logic [4:0] modeSel = 5'h00;
    logic modeStrobe = 1'b0;
    logic [11:0] driftIn = 12'h005;
    logic driftLoad = 1'b0;
    logic [11:0] speedCmd = 12'h123;
    wire mdValid, mdChange, faultPulse, jobActive, followMode, loopEnable, homeValid, dataValid;
    wire [23:0] mdStepCount, mdMaxStepChange, mdRangeLow, mdRangeHigh, mdHomeCoord, mdHomeReading, mdRefCoord;
    wire [23:0] actualValue;
    wire [7:0] hostFaultCode, pgmFaultCode;
    wire [11:0] speedOut;
    int num_errors = 0;
    int compares = 0;

    always #10 clk = ~clk;

    afs_host_model afs_host_model_inst (.clk, .mdValid, .mdChange, .mdStepCount, .mdMaxStepChange,
        .mdRangeLow, .mdRangeHigh, .mdHomeCoord, .mdHomeReading, .mdRefCoord);
    afs_supervisor #(.IS_ABSOLUTE(1)) afs_supervisor_inst (.clk, .nrst, .busResetPulse, .batteryOk,
        .encValid, .encReading, .mdValid, .mdChange, .mdStepCount, .mdMaxStepChange, .mdRangeLow,
        .mdRangeHigh, .mdHomeCoord, .mdHomeReading, .mdRefCoord, .jobStart, .modeSel, .modeStrobe,
        .driftIn, .driftLoad, .speedCmd, .hostFaultCode, .pgmFaultCode, .faultPulse, .jobActive,
        .followMode, .loopEnable, .homeValid, .dataValid, .actualValue, .speedOut);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic sample(input logic [23:0] r);
        @(posedge clk);
        encValid <= 1'b1;
        encReading <= r;
        @(posedge clk);
        encValid <= 1'b0;
    endtask

    task automatic restart(input logic b);
        @(posedge clk);
        batteryOk <= b;
        busResetPulse <= 1'b1;
        @(posedge clk);
        busResetPulse <= 1'b0;
        tick(0);
    endtask

    task automatic t_reset;
        tick(1);
        chk(hostFaultCode, 8'h00);
        chk({followMode, loopEnable, jobActive}, 3'b010);
        chk(speedOut, 12'h123);
        @(posedge clk);
        driftIn <= 12'h00A;
        driftLoad <= 1'b1;
        @(posedge clk);
        driftLoad <= 1'b0;
        $display("reset test done");
    endtask

    task automatic t_change;
        sample(24'h000064);
        sample(24'h00012D);
        tick(2);
        chk(hostFaultCode, 8'h3F);
        chk(pgmFaultCode, 8'hBF);
        chk({followMode, speedOut}, {1'b1, 12'h00A});
        afs_host_model_inst.push(24'h000032);
        tick(0);
        chk(followMode, 1'b0);
        $display("illegal change test done");
    endtask

    task automatic t_read;
        @(posedge clk);
        jobStart <= 1'b1;
        @(posedge clk);
        jobStart <= 1'b0;
        tick(1);
        chk(jobActive, 1'b1);
        sample(24'h000190);
        tick(2);
        chk(hostFaultCode, 8'h3C);
        chk(pgmFaultCode, 8'hBC);
        chk({followMode, loopEnable, jobActive, speedOut}, {3'b100, 12'h00A});
        afs_host_model_inst.push(24'h000032);
        tick(0);
        chk(followMode, 1'b0);
        sample(24'h000190);
        tick(2);
        chk(followMode, 1'b1);
        sample(24'h000186);
        afs_host_model_inst.push(24'h000032);
        $display("illegal reading test done");
    endtask

    task automatic t_home;
        afs_host_model_inst.push(24'h000190);
        repeat (8) if (hostFaultCode !== 8'h3D) tick(1);
        chk(hostFaultCode, 8'h3D);
        chk(pgmFaultCode, 8'hBD);
        $display("bad home test done");
    endtask

    task automatic t_restart;
        afs_host_model_inst.push(24'h000032);
        sample(24'h000150);
        @(posedge clk);
        modeSel <= 5'h05;
        modeStrobe <= 1'b1;
        @(posedge clk);
        modeStrobe <= 1'b0;
        tick(3);
        chk({dataValid, homeValid}, 2'b11);
        chk(actualValue, 24'h00021E);
        restart(1'b1);
        chk({jobActive, hostFaultCode}, 9'h000);
        chk({dataValid, homeValid}, 2'b11);
        restart(1'b0);
        chk({dataValid, homeValid}, 2'b00);
        $display("restart test done");
    endtask

    task automatic report_and_stop;
        $display("compares=%0d errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // generous bound: the whole sequence needs well under a thousand cycles
    initial
    begin
        #100000;
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_change();
        t_read();
        t_home();
        t_restart();
        report_and_stop();
    end
endmodule // tb_axis_fault_and_restart_supervisor
